// File: hw/tsec_pkg.sv
// How it works
// - Higher-priority event may preempt an active one
// - Lowest-numbered latched unmasked event wins grant
// - Emulation event enters emulation mode
// - Taking the reset class pulses core reset
// - Watchdog or nmi pin raises nonmaskable event
// - Exception holds offending instruction until taken
// - Misalign or undefined instruction raises exception
// - Interrupts from timers, peripherals, pins, software
// - Per-class return address and return resume
// - Each take pulses processor state push
// - Peripheral sources route through system stage
// - Nine general levels, numbered seven to fifteen
// - Fixed class priority order, zero highest
// - Each source maps to one general level
// - Default assignments after reset, software overridable
// - Error and supplemental sources default level seven
// - First DMA channels default level eight
// - Second DMA channels default level nine
// - Memory DMA streams default eight and nine
// - Timers level ten, flag interrupts level eleven
// - Internal memory DMA streams default level twelve
// - Latch sets on edge, clears when pending
// - Edge to pending takes at least three clocks
// - Source mask bit gates each source
// - Source status bit follows source request
package tsec_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_SRC = 64;
    localparam int NUM_EVT = 16;
    localparam int GP_FIRST = 7;
    localparam int GP_COUNT = 9;

    // ==========================================================
    // Event classes, 0 is most urgent
    localparam logic [3:0] CLS_EMU = 4'h0;
    localparam logic [3:0] CLS_RST = 4'h1;
    localparam logic [3:0] CLS_NMI = 4'h2;
    localparam logic [3:0] CLS_EXC = 4'h3;
    localparam logic [3:0] CLS_GEN = 4'h4;
    localparam logic [3:0] CLS_HWE = 4'h5;
    localparam logic [3:0] CLS_TMR = 4'h6;

    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] OFS_SRC_MASK0 = 8'h00;
    localparam logic [7:0] OFS_SRC_MASK1 = 8'h04;
    localparam logic [7:0] OFS_SRC_STAT0 = 8'h08;
    localparam logic [7:0] OFS_SRC_STAT1 = 8'h0c;
    localparam logic [7:0] OFS_ASSIGN0 = 8'h10;
    localparam logic [7:0] OFS_ASSIGN7 = 8'h2c;
    localparam logic [7:0] OFS_LATCH = 8'h30;
    localparam logic [7:0] OFS_CORE_MASK = 8'h34;
    localparam logic [7:0] OFS_PENDING = 8'h38;
    localparam logic [7:0] OFS_CTRL = 8'h3c;

    // Control register fields
    localparam int CTRL_GEN_EN_BIT = 0;
    localparam int CTRL_EMU_BIT = 1;

    // ==========================================================
    // Values after reset
    localparam logic [31:0] SRC_MASK_RST = 32'h0000_0000;
    localparam logic [15:0] CORE_MASK_RST = 16'h0000;
    localparam logic GEN_EN_RST = 1'b0;

    // Default general level for each source, stored as level minus 7
    function automatic logic [3:0] dflt_field(input int s);
        logic [3:0] f;
        f = 4'h0;
        if (s >= 11 && s <= 22) f = 4'h1;
        else if (s >= 23 && s <= 34) f = 4'h2;
        else if (s >= 35 && s <= 46) f = 4'h3;
        else if (s >= 47 && s <= 52) f = 4'h4;
        else if (s == 53 || s == 54) f = 4'h1;
        else if (s == 55 || s == 56) f = 4'h2;
        else if (s == 57 || s == 58) f = 4'h5;
        return f;
    endfunction

    function automatic logic [255:0] dflt_assign();
        logic [255:0] v;
        v = '0;
        for (int s = 0; s < NUM_SRC; s++) begin
            v[s*4 +: 4] = dflt_field(s);
        end
        return v;
    endfunction

    localparam logic [255:0] ASSIGN_RST = dflt_assign();

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } tsec_bus_req_t;

    typedef struct packed {
        logic valid;
        logic [3:0] cls;
    } tsec_take_t;

    // Lowest set index of a 16-bit vector, 4'hf when none
    function automatic logic [3:0] lowest(input logic [15:0] v);
        logic [3:0] r;
        r = 4'hf;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) r = 4'(i);
        end
        return r;
    endfunction

endpackage

// File: hw/tsec_top.sv
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
module tsec_top import tsec_pkg::*; #(
    parameter int ADDR_W = 32
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire tsec_bus_req_t bus_req,
    output logic [31:0] bus_rdata_ff,
    input wire logic [NUM_SRC-1:0] src_irq,
    input wire logic emu_req,
    input wire logic rst_req,
    input wire logic nmi_pin,
    input wire logic wdog_nmi,
    input wire logic misalign_exc,
    input wire logic undef_exc,
    input wire logic hw_err,
    input wire logic core_timer_irq,
    input wire logic sw_raise,
    input wire logic [3:0] sw_raise_lvl,
    input wire logic gen_enable_set,
    input wire logic gen_enable_clr,
    input wire logic [ADDR_W-1:0] pc_in,
    input wire logic rte_valid,
    output tsec_take_t take_ff,
    output logic push_state_ff,
    output logic core_reset_ff,
    output logic emu_mode_ff,
    output logic kill_commit_ff,
    output logic resume_valid_ff,
    output logic [ADDR_W-1:0] resume_addr_ff
);

    // ==========================================================
    // State
    logic [1:0][31:0] src_mask_ff; // Source mask bits
    logic [1:0][31:0] src_stat_ff; // Source status bits
    logic [255:0] assign_ff; // Source assignment registers, 4 bits each
    logic [15:0] latch_ff; // Event latch bits
    logic [15:0] core_mask_ff; // Core mask bits
    logic [15:0] pending_ff; // Event pending bits
    logic gen_en_ff; // Global enable for general levels
    logic [15:0] gl_ff; // Routed general level, first stage
    logic [15:0] gl_prev_ff; // Previous routed level, edge detect
    logic nmi_s1_ff;
    logic nmi_s2_ff;
    logic nmi_s3_ff;
    logic nmi_lvl_ff; // Filtered pin level
    logic [ADDR_W-1:0] ret_addr_ff [NUM_EVT]; // Return address per class

    // ==========================================================
    // System stage routing
    logic [15:0] gl_raw;
    logic [NUM_SRC-1:0] src_live;

    // Masked sources ORed onto their assigned level
    always_comb begin
        src_live = src_irq & {src_mask_ff[1], src_mask_ff[0]};
        gl_raw = '0;
        for (int s = 0; s < NUM_SRC; s++) begin
            for (int l = 0; l < GP_COUNT; l++) begin
                if (assign_ff[s*4 +: 4] == 4'(l)) begin
                    gl_raw[GP_FIRST + l] = gl_raw[GP_FIRST + l] | src_live[s];
                end
            end
        end
    end

    // Status follows the raw request, mask does not hide it
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            src_stat_ff <= '0;
        end else begin
            src_stat_ff <= {src_irq[63:32], src_irq[31:0]};
        end
    end

    // Two clocks of edge detection on the routed levels
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            gl_ff <= '0;
            gl_prev_ff <= '0;
        end else begin
            gl_ff <= gl_raw;
            gl_prev_ff <= gl_ff;
        end
    end

    // ==========================================================
    // Nonmaskable pin synchroniser
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            nmi_s1_ff <= 1'b0;
            nmi_s2_ff <= 1'b0;
            nmi_s3_ff <= 1'b0;
            nmi_lvl_ff <= 1'b0;
        end else begin
            nmi_s1_ff <= nmi_pin;
            nmi_s2_ff <= nmi_s1_ff;
            nmi_s3_ff <= nmi_s2_ff;
            // A change counts only once two stages agree, filters glitches
            if (nmi_s2_ff == nmi_s3_ff) begin
                nmi_lvl_ff <= nmi_s3_ff;
            end
        end
    end

    // ==========================================================
    // Core stage decision
    logic [15:0] raise; // Events arriving this cycle
    logic [15:0] eff_mask;
    logic [3:0] cand;
    logic [3:0] active;
    logic take_now;
    logic [15:0] take_bit;
    logic [15:0] rte_bit;
    logic nmi_edge;
    logic exc_now;

    assign nmi_edge = nmi_s3_ff & ~nmi_lvl_ff & nmi_s2_ff;
    assign exc_now = misalign_exc | undef_exc;

    // Gather raise requests per class
    always_comb begin
        raise = '0;
        raise[CLS_EMU] = emu_req;
        raise[CLS_RST] = rst_req;
        raise[CLS_NMI] = wdog_nmi | nmi_edge;
        raise[CLS_EXC] = exc_now;
        raise[CLS_HWE] = hw_err;
        raise[CLS_TMR] = core_timer_irq;
        for (int l = GP_FIRST; l < NUM_EVT; l++) begin
            // Rising edge or the software raise instruction
            raise[l] = (gl_ff[l] & ~gl_prev_ff[l]) | (sw_raise && sw_raise_lvl == 4'(l));
        end
    end

    // Top four classes cannot be masked; global enable gates 7..15
    always_comb begin
        eff_mask = core_mask_ff;
        eff_mask[3:0] = 4'hf;
        eff_mask[CLS_GEN] = 1'b0;
        eff_mask[15:7] = core_mask_ff[15:7] & {9{gen_en_ff}};
    end

    assign cand = lowest(latch_ff & eff_mask);
    // Most urgent in service, 4'hf when idle
    assign active = lowest(pending_ff);
    // A new take only when it outranks everything in service,
    // or when idle, so level 15 stays reachable
    assign take_now = ((latch_ff & eff_mask) != '0)
                      && (pending_ff == '0 || cand < active);
    assign take_bit = take_now ? (16'h0001 << cand) : 16'h0000;
    assign rte_bit = (rte_valid && pending_ff != '0) ? (16'h0001 << active) : 16'h0000;

    // ==========================================================
    // Register bus decode
    logic wr_latch;
    logic [15:0] latch_w1c;
    logic [2:0] asg_idx;

    assign wr_latch = bus_req.wr && bus_req.addr == OFS_LATCH;
    // Cancel only where the event is masked; set still wins below
    assign latch_w1c = wr_latch ? (bus_req.wdata[15:0] & ~core_mask_ff) : 16'h0000;
    assign asg_idx = bus_req.addr[4:2] - OFS_ASSIGN0[4:2];

    // Latch: edge sets, take or software cancel clears, set wins
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            latch_ff <= '0;
        end else begin
            latch_ff <= (latch_ff & ~take_bit & ~latch_w1c) | raise;
        end
    end

    // Pending: set on take, cleared by return from event
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pending_ff <= '0;
        end else begin
            pending_ff <= (pending_ff & ~rte_bit) | take_bit;
        end
    end

    // Software-written configuration
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            src_mask_ff <= {SRC_MASK_RST, SRC_MASK_RST};
            assign_ff <= ASSIGN_RST;
            core_mask_ff <= CORE_MASK_RST;
        end else if (bus_req.wr) begin
            if (bus_req.addr == OFS_SRC_MASK0) begin
                src_mask_ff[0] <= bus_req.wdata;
            end else if (bus_req.addr == OFS_SRC_MASK1) begin
                src_mask_ff[1] <= bus_req.wdata;
            end else if (bus_req.addr >= OFS_ASSIGN0 && bus_req.addr <= OFS_ASSIGN7
                         && bus_req.addr[1:0] == 2'b00) begin
                // Eight sources per word, four bits each
                assign_ff[asg_idx*32 +: 32] <= bus_req.wdata;
            end else if (bus_req.addr == OFS_CORE_MASK) begin
                core_mask_ff <= bus_req.wdata[15:0];
            end
        end
    end

    // Global enable: set and clear instructions, or control register
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            gen_en_ff <= GEN_EN_RST;
        end else if (gen_enable_set) begin
            gen_en_ff <= 1'b1;
        end else if (gen_enable_clr) begin
            gen_en_ff <= 1'b0;
        end else if (bus_req.wr && bus_req.addr == OFS_CTRL) begin
            gen_en_ff <= bus_req.wdata[CTRL_GEN_EN_BIT];
        end
    end

    // Read data stand for exactly one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            bus_rdata_ff <= '0;
        end else if (!bus_req.rd) begin
            bus_rdata_ff <= '0;
        end else if (bus_req.addr == OFS_SRC_MASK0) begin
            bus_rdata_ff <= src_mask_ff[0];
        end else if (bus_req.addr == OFS_SRC_MASK1) begin
            bus_rdata_ff <= src_mask_ff[1];
        end else if (bus_req.addr == OFS_SRC_STAT0) begin
            bus_rdata_ff <= src_stat_ff[0];
        end else if (bus_req.addr == OFS_SRC_STAT1) begin
            bus_rdata_ff <= src_stat_ff[1];
        end else if (bus_req.addr >= OFS_ASSIGN0 && bus_req.addr <= OFS_ASSIGN7
                     && bus_req.addr[1:0] == 2'b00) begin
            bus_rdata_ff <= assign_ff[asg_idx*32 +: 32];
        end else if (bus_req.addr == OFS_LATCH) begin
            bus_rdata_ff <= {16'h0000, latch_ff};
        end else if (bus_req.addr == OFS_CORE_MASK) begin
            bus_rdata_ff <= {16'h0000, core_mask_ff};
        end else if (bus_req.addr == OFS_PENDING) begin
            bus_rdata_ff <= {16'h0000, pending_ff};
        end else if (bus_req.addr == OFS_CTRL) begin
            bus_rdata_ff <= {30'h0000_0000, emu_mode_ff, gen_en_ff};
        end else begin
            // Unmapped addresses read as zero
            bus_rdata_ff <= '0;
        end
    end

    // ==========================================================
    // Sequencer side
    // Take announcement and state push go out together
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            take_ff <= '0;
            push_state_ff <= 1'b0;
            core_reset_ff <= 1'b0;
        end else begin
            take_ff.valid <= take_now;
            take_ff.cls <= take_now ? cand : 4'h0;
            push_state_ff <= take_now;
            core_reset_ff <= take_now && cand == CLS_RST;
        end
    end

    // Emulation mode lasts until its own return
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            emu_mode_ff <= 1'b0;
        end else if (take_now && cand == CLS_EMU) begin
            emu_mode_ff <= 1'b1;
        end else if (rte_bit[CLS_EMU]) begin
            emu_mode_ff <= 1'b0;
        end
    end

    // Hold the faulting instruction back until its exception is taken
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            kill_commit_ff <= 1'b0;
        end else begin
            kill_commit_ff <= exc_now | (latch_ff[CLS_EXC] & ~take_bit[CLS_EXC]);
        end
    end

    // Return address capture and resume
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            resume_valid_ff <= 1'b0;
            resume_addr_ff <= '0;
        end else begin
            resume_valid_ff <= rte_bit != '0;
            if (rte_bit != '0) begin
                resume_addr_ff <= ret_addr_ff[active];
            end
        end
    end

    // Return address store holds no control state, so it needs no reset
    always_ff @(posedge core_clk) begin
        if (take_now) begin
            ret_addr_ff[cand] <= pc_in;
        end
    end

    // ==========================================================
    // Checks
    a_grant_highest: assert property (@(posedge core_clk) disable iff (!rst_b)
        take_ff.valid |-> ($past(latch_ff & eff_mask) & ((16'h0001 << take_ff.cls) - 16'h0001)) == '0)
        else $error("grant skipped a more urgent latched event");

    a_nest_preempt: assert property (@(posedge core_clk) disable iff (!rst_b)
        (take_ff.valid && $past(pending_ff) != '0) |-> take_ff.cls < $past(active))
        else $error("take did not outrank the active event");

    a_latch_clears: assert property (@(posedge core_clk) disable iff (!rst_b)
        (take_now && !raise[cand]) |=> !latch_ff[$past(cand)] && pending_ff[$past(cand)])
        else $error("latch bit not moved to pending");

    a_min_latency: assert property (@(posedge core_clk) disable iff (!rst_b)
        ($rose(gl_raw[7]) && !latch_ff[7] && !pending_ff[7]) |-> ##1 !pending_ff[7] ##1 !pending_ff[7])
        else $error("pending came sooner than three clocks");

    a_reset_pulse: assert property (@(posedge core_clk) disable iff (!rst_b)
        core_reset_ff == (take_ff.valid && take_ff.cls == CLS_RST))
        else $error("reset pulse does not match reset take");

    a_emu_enter: assert property (@(posedge core_clk) disable iff (!rst_b)
        (take_now && cand == CLS_EMU) |=> emu_mode_ff [*2])
        else $error("emulation mode not entered");

    a_exc_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
        exc_now |=> kill_commit_ff)
        else $error("exception did not hold the instruction");

    a_push_state: assert property (@(posedge core_clk) disable iff (!rst_b)
        $rose(take_ff.valid) |-> push_state_ff && $past(take_now))
        else $error("state push missing on take");

    a_status_follow: assert property (@(posedge core_clk) disable iff (!rst_b)
        ##1 {src_stat_ff[1], src_stat_ff[0]} == $past(src_irq))
        else $error("source status does not follow request");

    a_mask_block: assert property (@(posedge core_clk) disable iff (!rst_b)
        ({src_mask_ff[1], src_mask_ff[0]} == '0) |-> gl_raw == '0)
        else $error("masked source reached a level");

    a_default_map: assert property (@(posedge core_clk)
        $rose(rst_b) |-> assign_ff == ASSIGN_RST)
        else $error("assignments not at default after reset");

    a_rte_resume: assert property (@(posedge core_clk) disable iff (!rst_b)
        (rte_valid && pending_ff != '0) |=> resume_valid_ff
            ##1 (!resume_valid_ff || $past(rte_valid)))
        else $error("return did not resume once");

    a_idle_take: assert property (@(posedge core_clk) disable iff (!rst_b)
        (pending_ff == '0 && (latch_ff & eff_mask) != '0) |=> take_ff.valid)
        else $error("idle event not taken");

    // Main scenarios
    c_nested: cover property (@(posedge core_clk) disable iff (!rst_b)
        take_ff.valid && $past(pending_ff) != '0);
    c_nmi_pin: cover property (@(posedge core_clk) disable iff (!rst_b)
        take_ff.valid && take_ff.cls == CLS_NMI);
    c_gp_take: cover property (@(posedge core_clk) disable iff (!rst_b)
        take_ff.valid && take_ff.cls == 4'h8);
    c_resume: cover property (@(posedge core_clk) disable iff (!rst_b) resume_valid_ff);
    c_sw_low: cover property (@(posedge core_clk) disable iff (!rst_b)
        take_ff.valid && take_ff.cls == 4'hf);

endmodule

// File: dv/tsec_src_model.sv
`timescale 1ns/1ps
// ==========================================================
// Peripheral side: drives the source request lines
module tsec_src_model import tsec_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [3:0] lag,
    input wire logic [NUM_SRC-1:0] pat,
    output logic [NUM_SRC-1:0] src_irq
);
    logic [NUM_SRC-1:0] pat_ff; // Pattern to show next
    logic [3:0] wait_ff; // Cycles before it shows

    // Slow peripherals: a lag delays the new levels
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pat_ff <= '0;
            wait_ff <= 4'h0;
            src_irq <= '0;
        end else if (load) begin
            pat_ff <= pat;
            wait_ff <= lag;
        end else if (wait_ff != 4'h0) begin
            wait_ff <= wait_ff - 4'h1;
        end else begin
            src_irq <= pat_ff;
        end
    end
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench import tsec_pkg::*;;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    tsec_bus_req_t bus_req = '0;
    logic [31:0] bus_rdata_ff;
    logic [9:0] ev = '0; // Core event inputs and rte
    logic [3:0] sw_lvl = 4'h0;
    logic gs = 1'b0;
    logic gc = 1'b0;
    logic [31:0] pc = '0;
    tsec_take_t take_ff;
    logic push_state_ff, core_reset_ff, emu_mode_ff, kill_commit_ff, resume_valid_ff;
    logic [31:0] resume_addr_ff;
    logic [63:0] src_irq;
    logic [63:0] m_pat = '0;
    logic m_load = 1'b0;
    logic [3:0] m_lag = 4'h0;
    int fails = 0;
    int samples_checked = 0;
    int seed = 32'h12208eb9;
    int lat;
    logic [31:0] ret [16]; // Return address per class
    int cls_of [8] = '{0, 1, 2, 3, 3, 5, 6, 2};

    always #4 core_clk = ~core_clk;

    tsec_top dut (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req),
        .bus_rdata_ff(bus_rdata_ff), .src_irq(src_irq), .emu_req(ev[0]), .rst_req(ev[1]),
        .wdog_nmi(ev[2]), .misalign_exc(ev[3]), .undef_exc(ev[4]), .hw_err(ev[5]),
        .core_timer_irq(ev[6]), .nmi_pin(ev[7]), .sw_raise(ev[8]), .sw_raise_lvl(sw_lvl),
        .gen_enable_set(gs), .gen_enable_clr(gc), .pc_in(pc), .rte_valid(ev[9]),
        .take_ff(take_ff), .push_state_ff(push_state_ff), .core_reset_ff(core_reset_ff),
        .emu_mode_ff(emu_mode_ff), .kill_commit_ff(kill_commit_ff),
        .resume_valid_ff(resume_valid_ff), .resume_addr_ff(resume_addr_ff));

    tsec_src_model u_src (.core_clk(core_clk), .rst_b(rst_b), .load(m_load), .lag(m_lag),
        .pat(m_pat), .src_irq(src_irq));

    // ==========================================================
    // Expectations
    function automatic logic [3:0] dlvl(int s);
        if ((s >= 11 && s <= 22) || s == 53 || s == 54) return 4'h1;
        if ((s >= 23 && s <= 34) || s == 55 || s == 56) return 4'h2;
        if (s >= 35 && s <= 46) return 4'h3;
        if (s >= 47 && s <= 52) return 4'h4;
        if (s == 57 || s == 58) return 4'h5;
        return 4'h0;
    endfunction

    function automatic logic [31:0] dword(int r);
        logic [31:0] w;
        for (int j = 0; j < 8; j++) w[j*4 +: 4] = dlvl(r * 8 + j);
        return w;
    endfunction

    // ==========================================================
    // Shared tasks
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        bus_req <= '0;
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_chk(string what, logic [7:0] a, logic [31:0] exp);
        @(posedge core_clk);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge core_clk);
        bus_req <= '0;
        #1 check(what, bus_rdata_ff, exp);
    endtask

    task automatic raise(logic [9:0] m, int hold);
        @(posedge core_clk);
        pc <= $random(seed);
        ev <= m;
        repeat (hold) @(posedge core_clk);
        ev <= '0;
        #1;
    endtask

    // Looks at the current cycle first, so a take right after a return is seen
    task automatic wait_take(int cls);
        lat = 0;
        while (take_ff.valid !== 1'b1 && lat < 40) begin
            @(posedge core_clk);
            #1 lat++;
        end
        check("take", 32'(take_ff), {27'h0, 1'b1, 4'(cls)});
        check("push", 32'(push_state_ff), 32'h1);
        check("core reset", 32'(core_reset_ff), 32'(cls == 1));
        if (cls == 0) check("emu mode", 32'(emu_mode_ff), 32'h1);
        ret[cls] = pc;
    endtask

    task automatic ret_chk(int cls);
        @(posedge core_clk);
        ev[9] <= 1'b1;
        @(posedge core_clk);
        ev[9] <= 1'b0;
        #1 check("resume valid", 32'(resume_valid_ff), 32'h1);
        check("resume addr", resume_addr_ff, ret[cls]);
    endtask

    // One source through the system stage; en low leaves it masked
    task automatic route(int s, int lvl, bit en);
        logic [63:0] m;
        int n;
        bit bad;
        m = en ? 64'h1 << s : 64'h0;
        wr(OFS_SRC_MASK0, m[31:0]);
        wr(OFS_SRC_MASK1, m[63:32]);
        @(posedge core_clk);
        m_pat <= 64'h1 << s;
        m_load <= 1'b1;
        @(posedge core_clk);
        m_load <= 1'b0;
        n = 0;
        bad = 0;
        do begin
            @(posedge core_clk);
            #1 n++;
        end while (src_irq[s] !== 1'b1 && n < 20);
        if (en) begin
            wait_take(lvl);
            check("min latency", 32'(lat >= 3), 32'h1);
            rd_chk("pending", OFS_PENDING, 32'h1 << lvl);
            rd_chk("latch", OFS_LATCH, 32'h0);
            ret_chk(lvl);
        end else begin
            repeat (12) begin
                @(posedge core_clk);
                #1 if (take_ff.valid !== 1'b0) bad = 1;
            end
            check("masked take", 32'(bad), 32'h0);
        end
        wr(OFS_LATCH, 32'h0);
        @(posedge core_clk);
        m_pat <= '0;
        m_load <= 1'b1;
        @(posedge core_clk);
        m_load <= 1'b0;
        repeat (3) @(posedge core_clk);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        int s;
        logic [3:0] f;
        logic [31:0] w;
        logic [63:0] p;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        rd_chk("mask lo", OFS_SRC_MASK0, 32'h0);
        rd_chk("core mask", OFS_CORE_MASK, 32'h0);
        rd_chk("unmapped", 8'h40, 32'h0);
        for (int r = 0; r < 8; r++) rd_chk("assign", OFS_ASSIGN0 + 8'(r * 4), dword(r));
        // Raw requests show in status, even while masked
        for (int i = 0; i < 4; i++) begin
            p = {$random(seed), $random(seed)};
            @(posedge core_clk);
            m_pat <= p;
            m_lag <= 4'(i * 3);
            m_load <= 1'b1;
            @(posedge core_clk);
            m_load <= 1'b0;
            repeat (i * 3 + 3) @(posedge core_clk);
            rd_chk("status lo", OFS_SRC_STAT0, p[31:0]);
            rd_chk("status hi", OFS_SRC_STAT1, p[63:32]);
        end
        m_lag <= 4'h0;
        m_pat <= '0;
        m_load <= 1'b1;
        @(posedge core_clk);
        m_load <= 1'b0;
        wr(OFS_CORE_MASK, 32'hffff);
        @(posedge core_clk);
        gs <= 1'b1;
        @(posedge core_clk);
        gs <= 1'b0;
        rd_chk("ctrl set", OFS_CTRL, 32'h1);
        @(posedge core_clk);
        gc <= 1'b1;
        @(posedge core_clk);
        gc <= 1'b0;
        rd_chk("ctrl clr", OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h1);
        // Every dedicated class on its own
        for (int i = 0; i < 8; i++) begin
            raise(10'(1 << i), i == 7 ? 4 : 1);
            if (i == 3 || i == 4) check("kill", 32'(kill_commit_ff), 32'h1);
            wait_take(cls_of[i]);
            ret_chk(cls_of[i]);
            if (i == 0) check("emu exit", 32'(emu_mode_ff), 32'h0);
        end
        // Two at once, then nesting on top of the loser
        raise(10'h060, 1);
        wait_take(5);
        ret_chk(5);
        wait_take(6);
        raise(10'h001, 1);
        wait_take(0);
        ret_chk(0);
        ret_chk(6);
        // Software raise uses the two levels kept for it
        for (int l = 14; l <= 15; l++) begin
            sw_lvl <= 4'(l);
            raise(10'h100, 1);
            wait_take(l);
            ret_chk(l);
        end
        // Masked latch, then cancel
        wr(OFS_CORE_MASK, 32'hdfff);
        sw_lvl <= 4'hd;
        raise(10'h100, 1);
        rd_chk("latch held", OFS_LATCH, 32'h2000);
        wr(OFS_LATCH, 32'h2000);
        rd_chk("latch w1c", OFS_LATCH, 32'h0);
        wr(OFS_CORE_MASK, 32'hffff);
        route(0, 7, 1);
        route(63, 7, 1);
        route(58, 12, 1);
        route(11, 8, 0);
        for (int i = 0; i < 6; i++) begin
            s = int'($unsigned($random(seed)) % 59);
            route(s, 7 + int'(dlvl(s)), 1);
        end
        for (int i = 0; i < 3; i++) begin
            s = int'($unsigned($random(seed)) % 59);
            f = 4'($unsigned($random(seed)) % 7);
            w = dword(s / 8);
            w[(s % 8) * 4 +: 4] = f;
            wr(OFS_ASSIGN0 + 8'((s / 8) * 4), w);
            rd_chk("assign new", OFS_ASSIGN0 + 8'((s / 8) * 4), w);
            route(s, 7 + int'(f), 1);
            wr(OFS_ASSIGN0 + 8'((s / 8) * 4), dword(s / 8));
        end
        test_done();
    end

    // Hang guard, far past the run
    initial begin
        repeat (20000) @(posedge core_clk);
        fails++;
        test_done();
    end
endmodule
